// File: verilog/exec_defines.svh
// opcode patterns, field positions and reset values of the execute block
// included by the execute core only; definitions only
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// full-word opcodes
`define OP_NOP 14'h0000
`define OP_SUB_EXIT 14'h0040
`define OP_IRQ_EXIT 14'h0060
`define OP_SLEEP 14'h0003

// upper six bits of literal and file-register opcodes
`define OP6_LIT_EXIT 6'h18
`define OP6_LIT_MINUS_W 6'h1D
`define OP6_FILE_MINUS_W 6'h02
`define OP6_ROT_LEFT 6'h0D
`define OP6_ROT_RIGHT 6'h0C
// upper eight bits of the low-file move
`define OP8_LOW_MOVE 8'h00

// field positions
`define DEST_BIT 7
`define LOW_ADDR_MSB 5
`define FILE_ADDR_MSB 6
`define LIT_MSB 7

// reset values
`define W_RST 8'h00
`define FLAG_RST 1'b0
`define TIMEOUT_RST 1'b1
`define POWERDOWN_RST 1'b1
`define GIE_RST 1'b0

`endif

// File: verilog/exec_pkg.sv
// types shared by the execute block and its arithmetic unit
// no timing or reset values live here, see exec_defines.svh
package exec_pkg;
   typedef enum logic [1:0] {ALU_PASS, ALU_SUB, ALU_RLC, ALU_RRC} alu_op_t;
   typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_WAIT, ST_SLEEP} exec_st_t;
   typedef logic [11:0] pc_t;
endpackage

// File: verilog/alu_if.sv
// carrier between the execute control and its arithmetic unit
// purely combinational signals, no clock inside
`timescale 1ns/1ps
interface alu_if;
   import exec_pkg::*;
   alu_op_t op;
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic carry_in;
   logic [7:0] result;
   logic c_out;
   logic dc_out;
   logic z_out;
   modport user (output op, minuend, subtrahend, carry_in,
                 input result, c_out, dc_out, z_out);
   modport unit (input op, minuend, subtrahend, carry_in,
                 output result, c_out, dc_out, z_out);
endinterface

// File: verilog/exec_alu.sv
// subtract and rotate-through-carry unit
// combinational; the caller registers results and flags
`timescale 1ns/1ps
module exec_alu
   import exec_pkg::*;
(
   alu_if.unit bus // operands in, result and flags out
);
   wire [8:0] diff_full;
   wire [4:0] diff_low;
   wire [7:0] rot_left;
   wire [7:0] rot_right;

   // two's complement subtract
   // borrow-free means carry out of minuend + ~subtrahend + 1
   assign diff_full = {1'b0, bus.minuend} + {1'b0, ~bus.subtrahend} + 9'h001;
   assign diff_low = {1'b0, bus.minuend[3:0]} + {1'b0, ~bus.subtrahend[3:0]}
                     + 5'h01;
   assign rot_left = {bus.minuend[6:0], bus.carry_in};
   assign rot_right = {bus.carry_in, bus.minuend[7:1]};

   assign bus.result = (bus.op == ALU_SUB) ? diff_full[7:0] :
                       (bus.op == ALU_RLC) ? rot_left :
                       (bus.op == ALU_RRC) ? rot_right : bus.minuend;
   assign bus.c_out = (bus.op == ALU_SUB) ? diff_full[8] :
                      (bus.op == ALU_RLC) ? bus.minuend[7] :
                      (bus.op == ALU_RRC) ? bus.minuend[0] : bus.carry_in;
   assign bus.dc_out = diff_low[4];
   assign bus.z_out = (bus.result == 8'h00);
endmodule

// File: verilog/exec_core.sv
// execute logic for a subset of the 14-bit instruction set
// assumes program memory, register file and stack sit outside on this clock
// Operation
// - low-file move copies working register, no flags
// - all-zero word does nothing, one cycle
// - subroutine exit pops stack into counter, two cycles
// - interrupt exit pops stack, sets interrupt enable
// - literal exit loads literal, pops stack, two cycles
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - destination bit picks working or file register
// - sleep stops oscillator, updates status flags
// - literal minus working into working, flags
// - file minus working to destination, flags
// - carry means no borrow; zero on zero
`timescale 1ns/1ps
`include "exec_defines.svh"
module exec_core
   import exec_pkg::*;
(
   input wire logic clock, // 20 MHz core clock
   input wire logic rst, // async reset, active high
   input wire logic [13:0] instr_word, // word from program memory
   input wire logic instr_valid, // instr_word is present
   output logic instr_ready, // core takes a word this cycle
   output logic [6:0] file_rd_addr, // read address to register file
   input wire logic [7:0] file_rd_data, // data at file_rd_addr
   output logic file_wr_en, // one-cycle file write strobe
   output logic [6:0] file_wr_addr, // file write address
   output logic [7:0] file_wr_data, // file write data
   input wire pc_t stack_top_entry, // current top of stack
   output logic stack_pop, // one-cycle pop strobe
   output logic pc_load, // one-cycle counter load strobe
   output pc_t pc_load_value, // value for the counter
   input wire logic gie_clear, // clears global_irq_enable
   output logic global_irq_enable, // interrupt enable level
   output logic [7:0] w_reg, // working register
   output logic carry_flag, // carry / not-borrow
   output logic half_carry_flag, // nibble carry / not-borrow
   output logic zero_flag, // zero result
   output logic timeout_flag, // time-out status
   output logic powerdown_flag, // power-down status
   output logic wdt_clear, // one-cycle watchdog clear
   output logic osc_stop, // oscillator stop, high in sleep
   input wire logic wake_pin // asynchronous wake request
);
   exec_st_t state_r, state_nxt;
   logic [13:0] ir_r;
   logic [7:0] w_r;
   logic wake_s1_r, wake_s2_r;
   alu_if alu ();

   ////////////////////////////////////////////////////////////////////
   // decode
   wire [5:0] top6 = ir_r[13:8];
   wire exec = (state_r == ST_EXEC);
   // all-zero word decodes to no write at all
   wire is_nop = (ir_r == `OP_NOP);
   wire is_sleep = (ir_r == `OP_SLEEP);
   wire is_ret = (ir_r == `OP_SUB_EXIT);
   wire is_interrupt_exit = (ir_r == `OP_IRQ_EXIT);
   // nop and sleep share the low-move pattern and take priority over it
   wire is_w_to_low_file_move = (ir_r[13:6] == `OP8_LOW_MOVE) && !is_nop && !is_sleep;
   wire is_literal_exit = (top6 == `OP6_LIT_EXIT);
   wire is_literal_minus_w = (top6 == `OP6_LIT_MINUS_W);
   wire is_file_minus_w = (top6 == `OP6_FILE_MINUS_W);
   wire is_rlf = (top6 == `OP6_ROT_LEFT);
   wire is_rrf = (top6 == `OP6_ROT_RIGHT);
   wire is_sub = is_literal_minus_w || is_file_minus_w;
   // file subtract and both rotates routed by destination bit
   wire is_file_op = is_file_minus_w || is_rlf || is_rrf;
   wire two_cycle = is_ret || is_interrupt_exit || is_literal_exit;
   wire pops = exec && two_cycle;
   // destination bit clear selects working register
   wire dest_file = ir_r[`DEST_BIT];
   wire wr_w = exec && ((is_file_op && !dest_file) || is_literal_minus_w || is_literal_exit);
   wire wr_f = exec && ((is_file_op && dest_file) || is_w_to_low_file_move);
   wire upd_c = exec && (is_sub || is_rlf || is_rrf);
   wire upd_dz = exec && is_sub;
   wire [7:0] lit = ir_r[`LIT_MSB:0];

   ////////////////////////////////////////////////////////////////////
   // arithmetic unit hookup
   // literal is minuend for literal_minus_w
   assign alu.op = is_sub ? ALU_SUB : is_rlf ? ALU_RLC :
                   is_rrf ? ALU_RRC : ALU_PASS;
   assign alu.minuend = is_literal_minus_w ? lit : file_rd_data;
   assign alu.subtrahend = w_r;
   assign alu.carry_in = carry_flag;

   exec_alu u_alu (
      .bus (alu)
   );

   // literal exit writes the literal, otherwise the unit result
   wire [7:0] w_nxt = is_literal_exit ? lit : alu.result;
   // low move writes working register to 6-bit address
   wire [7:0] fdata_nxt = is_w_to_low_file_move ? w_r : alu.result;
   wire [6:0] faddr_nxt = is_w_to_low_file_move ? {1'b0, ir_r[`LOW_ADDR_MSB:0]}
                                   : ir_r[`FILE_ADDR_MSB:0];

   ////////////////////////////////////////////////////////////////////
   // sequencing
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_FETCH: if (instr_valid) state_nxt = ST_EXEC;
         // two-cycle instructions spend a wait cycle
         ST_EXEC: state_nxt = is_sleep ? ST_SLEEP :
                              two_cycle ? ST_WAIT : ST_FETCH;
         ST_WAIT: state_nxt = ST_FETCH;
         // sleep holds until a wake request
         ST_SLEEP: if (wake_s2_r) state_nxt = ST_FETCH;
         default: state_nxt = ST_FETCH;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_FETCH;
         instr_ready <= 1'b1;
         ir_r <= `OP_NOP;
         file_rd_addr <= 7'h00;
      end
      else
      begin
         state_r <= state_nxt;
         instr_ready <= (state_nxt == ST_FETCH);
         if (state_r == ST_FETCH && instr_valid)
         begin
            ir_r <= instr_word;
            file_rd_addr <= instr_word[`FILE_ADDR_MSB:0];
         end
      end
   end

   // wake pin is asynchronous; only the second stage is read
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
      end
      else
      begin
         wake_s1_r <= wake_pin;
         wake_s2_r <= wake_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // working register and file write port
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         w_r <= `W_RST;
         file_wr_en <= 1'b0;
         file_wr_addr <= 7'h00;
         file_wr_data <= 8'h00;
      end
      else
      begin
         if (wr_w)
            w_r <= w_nxt;
         file_wr_en <= wr_f;
         if (wr_f)
         begin
            file_wr_addr <= faddr_nxt;
            file_wr_data <= fdata_nxt;
         end
      end
   end
   assign w_reg = w_r;

   ////////////////////////////////////////////////////////////////////
   // status flags
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         carry_flag <= `FLAG_RST;
         half_carry_flag <= `FLAG_RST;
         zero_flag <= `FLAG_RST;
      end
      else
      begin
         // carry from the subtract and rotates; half carry and zero from the subtract
         if (upd_c)
            carry_flag <= alu.c_out;
         if (upd_dz)
         begin
            half_carry_flag <= alu.dc_out;
            zero_flag <= alu.z_out;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stack return, interrupt enable, sleep
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stack_pop <= 1'b0;
         pc_load <= 1'b0;
         pc_load_value <= 12'h000;
         global_irq_enable <= `GIE_RST;
         timeout_flag <= `TIMEOUT_RST;
         powerdown_flag <= `POWERDOWN_RST;
         wdt_clear <= 1'b0;
         osc_stop <= 1'b0;
      end
      else
      begin
         // pop and load the counter from stack top
         stack_pop <= pops;
         pc_load <= pops;
         if (pops)
            pc_load_value <= stack_top_entry;
         // set wins over a simultaneous clear
         if (exec && is_interrupt_exit)
            global_irq_enable <= 1'b1;
         else if (gie_clear)
            global_irq_enable <= 1'b0;
         wdt_clear <= exec && is_sleep;
         if (exec && is_sleep)
         begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
         end
         osc_stop <= (state_nxt == ST_SLEEP);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   // low move
   chk_low_move_write: assert property (@(posedge clock) disable iff (rst)
      exec && is_w_to_low_file_move |=> file_wr_en && file_wr_data == $past(w_r)
         && file_wr_addr == {1'b0, $past(ir_r[5:0])}
         && $stable(carry_flag) && $stable(zero_flag))
      else $error("low move write wrong");
   chk_nop_quiet: assert property (@(posedge clock) disable iff (rst)
      exec && is_nop |=> !file_wr_en && $stable(w_r) && !stack_pop
         && $stable(carry_flag) && instr_ready)
      else $error("nop changed state");
   chk_return_pop: assert property (@(posedge clock) disable iff (rst)
      exec && is_ret |=> stack_pop && pc_load && !instr_ready
         && pc_load_value == $past(stack_top_entry) ##1 instr_ready)
      else $error("return pop wrong");
   chk_irq_exit_gie: assert property (@(posedge clock) disable iff (rst)
      exec && is_interrupt_exit |=> global_irq_enable && pc_load)
      else $error("interrupt exit did not enable");
   chk_lit_exit_w: assert property (@(posedge clock) disable iff (rst)
      exec && is_literal_exit |=> w_r == $past(ir_r[7:0]) && stack_pop)
      else $error("literal exit wrong");
   chk_rot_left_c: assert property (@(posedge clock) disable iff (rst)
      exec && is_rlf |=> carry_flag == $past(file_rd_data[7]))
      else $error("rotate left carry wrong");
   chk_rot_right_c: assert property (@(posedge clock) disable iff (rst)
      exec && is_rrf && !ir_r[7] |=> carry_flag == $past(file_rd_data[0])
         && w_r == {$past(carry_flag), $past(file_rd_data[7:1])})
      else $error("rotate right wrong");
   chk_dest_file: assert property (@(posedge clock) disable iff (rst)
      exec && is_file_op && ir_r[7] |=> file_wr_en && $stable(w_r)
         && file_wr_addr == $past(ir_r[6:0]))
      else $error("destination file wrong");
   chk_sleep_flags: assert property (@(posedge clock) disable iff (rst)
      exec && is_sleep |=> osc_stop && timeout_flag && !powerdown_flag
         && wdt_clear)
      else $error("sleep entry wrong");
   chk_sub_flags: assert property (@(posedge clock) disable iff (rst)
      exec && is_sub |=> carry_flag == ($past(alu.minuend) >= $past(w_r))
         && zero_flag == ($past(alu.minuend) == $past(w_r)))
      else $error("subtract flags wrong");
   cov_return: cover property (@(posedge clock) disable iff (rst)
      exec && is_ret ##2 instr_ready);
   cov_sleep_wake: cover property (@(posedge clock) disable iff (rst)
      osc_stop ##1 !osc_stop);
   cov_sub_borrow: cover property (@(posedge clock) disable iff (rst)
      exec && is_file_minus_w ##1 !carry_flag);
endmodule

// File: verification/regfile_model.sv
// behavioural register file that sits on the far side of the execute core
// assumes the core's clock; reads are combinational, writes on the edge
`timescale 1ns/1ps
module regfile_model
(
   input wire logic clock, // core clock
   input wire logic [6:0] file_rd_addr, // read address from core
   output logic [7:0] file_rd_data, // data at read address
   input wire logic file_wr_en, // write strobe from core
   input wire logic [6:0] file_wr_addr, // write address from core
   input wire logic [7:0] file_wr_data // write data from core
);
   logic [7:0] mem [128];

   ////////////////////////////////////////////////////////////////////////
   // fill with a known pattern so the bench can mirror it
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i * 37 + 5);
   end

   assign file_rd_data = mem[file_rd_addr];

   always @(posedge clock)
   begin
      if (file_wr_en === 1'b1)
         mem[file_wr_addr] <= file_wr_data;
   end
endmodule

// File: verification/mcu_instruction_subset_exec_tb.sv
// self-checking bench for the execute core with a register file model
// assumes the core takes a word on valid and ready, effects one edge later
`timescale 1ns/1ps
module mcu_instruction_subset_exec_tb;
   import exec_pkg::*;
   logic clock, rst, instr_valid, instr_ready, file_wr_en, stack_pop;
   logic pc_load, gie_clear, global_irq_enable, carry_flag, zero_flag;
   logic half_carry_flag, timeout_flag, powerdown_flag, wdt_clear;
   logic osc_stop, wake_pin;
   logic [13:0] instr_word;
   logic [6:0] file_rd_addr, file_wr_addr;
   logic [7:0] file_rd_data, file_wr_data, w_reg, exp_w;
   logic [7:0] exp_mem [128];
   logic exp_c, exp_dc, exp_z;
   pc_t stack_top_entry, pc_load_value;
   int n_fail, n_checks;

   exec_core dut_u (.clock(clock), .rst(rst), .instr_word(instr_word),
      .instr_valid(instr_valid), .instr_ready(instr_ready),
      .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
      .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
      .file_wr_data(file_wr_data), .stack_top_entry(stack_top_entry),
      .stack_pop(stack_pop), .pc_load(pc_load),
      .pc_load_value(pc_load_value), .gie_clear(gie_clear),
      .global_irq_enable(global_irq_enable), .w_reg(w_reg),
      .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
      .zero_flag(zero_flag), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .wdt_clear(wdt_clear),
      .osc_stop(osc_stop), .wake_pin(wake_pin));

   regfile_model far_u (.clock(clock), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   ///////////////////////////////////////////////////////////////////////
   task automatic chk_bit(input string name, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chk_byte(input string name, input logic [7:0] e,
                           input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chk_pc(input string name, input pc_t e, input pc_t g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // expected difference with the no-borrow carry on top
   function automatic logic [8:0] sub_exp(input logic [7:0] a,
                                          input logic [7:0] b);
      return {a >= b, 8'(a - b)};
   endfunction

   ///////////////////////////////////////////////////////////////////////
   // offer one word and return just after the edge its effects land on,
   // while the one-cycle pulses still stand
   task automatic run(input logic [13:0] word);
      int n;
      n = 0;
      while (instr_ready !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      chk_bit("instr_ready", 1'b1, instr_ready);
      instr_word = word;
      instr_valid = 1'b1;
      @(posedge clock);
      #1;
      instr_valid = 1'b0;
      instr_word = 14'($urandom);
      @(posedge clock);
      #1;
   endtask

   task automatic check_state();
      chk_byte("w_reg", exp_w, w_reg);
      chk_bit("carry_flag", exp_c, carry_flag);
      chk_bit("half_carry_flag", exp_dc, half_carry_flag);
      chk_bit("zero_flag", exp_z, zero_flag);
   endtask

   task automatic lit_sub(input logic [7:0] k);
      exp_dc = k[3:0] >= exp_w[3:0];
      {exp_c, exp_w} = sub_exp(k, exp_w);
      exp_z = exp_w == 8'h00;
      run({6'h1D, k});
      check_state();
   endtask

   // kind 0 subtract, 1 rotate left, 2 rotate right
   task automatic fop(input int kind, input logic d, input logic [6:0] f);
      logic [7:0] a, r;
      logic [5:0] hi;
      a = exp_mem[f];
      if (kind == 0)
      begin
         exp_dc = a[3:0] >= exp_w[3:0];
         {exp_c, r} = sub_exp(a, exp_w);
         exp_z = r == 8'h00;
         hi = 6'h02;
      end
      else if (kind == 1)
      begin
         r = {a[6:0], exp_c};
         exp_c = a[7];
         hi = 6'h0D;
      end
      else
      begin
         r = {exp_c, a[7:1]};
         exp_c = a[0];
         hi = 6'h0C;
      end
      run({hi, d, f});
      chk_bit("file_wr_en", d, file_wr_en);
      if (d)
      begin
         exp_mem[f] = r;
         chk_byte("file_wr_addr", {1'b0, f}, {1'b0, file_wr_addr});
         chk_byte("file_wr_data", r, file_wr_data);
      end
      else
         exp_w = r;
      check_state();
   endtask

   task automatic mv(input logic [5:0] r);
      exp_mem[r] = exp_w;
      run({8'h00, r});
      chk_bit("file_wr_en", 1'b1, file_wr_en);
      chk_byte("file_wr_addr", {2'b00, r}, {1'b0, file_wr_addr});
      chk_byte("file_wr_data", exp_w, file_wr_data);
      check_state();
   endtask

   task automatic ret(input logic [13:0] word);
      pc_t top;
      top = pc_t'($urandom);
      stack_top_entry = top;
      if (word[13:8] == 6'h18)
         exp_w = word[7:0];
      run(word);
      chk_bit("stack_pop", 1'b1, stack_pop);
      chk_bit("pc_load", 1'b1, pc_load);
      chk_pc("pc_load_value", top, pc_load_value);
      chk_bit("instr_ready", 1'b0, instr_ready);
      check_state();
   endtask

   ///////////////////////////////////////////////////////////////////////
   initial
   begin
      #(50 * 6000);
      n_fail++;
      report_and_stop();
   end

   initial
   begin
      int n;
      void'($urandom(32'h3F0363B7));
      rst = 1'b1;
      instr_word = 14'h0000;
      instr_valid = 1'b0;
      stack_top_entry = 12'h000;
      gie_clear = 1'b0;
      wake_pin = 1'b0;
      for (int i = 0; i < 128; i++)
         exp_mem[i] = 8'(i * 37 + 5);
      {exp_w, exp_c, exp_dc, exp_z} = 11'h000;
      repeat (12) @(posedge clock);
      #1;
      rst = 1'b0;
      chk_bit("timeout_flag", 1'b1, timeout_flag);
      chk_bit("powerdown_flag", 1'b1, powerdown_flag);
      chk_bit("global_irq_enable", 1'b0, global_irq_enable);
      check_state();
      ret(14'h1810);
      lit_sub(8'h15);
      ret(14'h1810);
      lit_sub(8'h10);
      ret(14'h1810);
      lit_sub(8'h05);
      mv(6'h3F);
      fop(0, 1'b1, 7'h7F);
      ret(14'h0060);
      chk_bit("global_irq_enable", 1'b1, global_irq_enable);
      gie_clear = 1'b1;
      @(posedge clock);
      #1;
      gie_clear = 1'b0;
      ret(14'h0040);
      chk_bit("global_irq_enable", 1'b0, global_irq_enable);
      for (int i = 0; i < 70; i++)
      begin
         case ($urandom % 7)
            0: lit_sub(8'($urandom));
            1: fop(0, 1'($urandom), 7'($urandom));
            2: fop(1, 1'($urandom), 7'($urandom));
            3: fop(2, 1'($urandom), 7'($urandom));
            4: mv(6'(4 + $urandom % 60));
            5: ret({6'h18, 8'($urandom)});
            default:
            begin
               run(14'h0000);
               chk_bit("file_wr_en", 1'b0, file_wr_en);
               check_state();
            end
         endcase
      end
      run(14'h0003);
      chk_bit("osc_stop", 1'b1, osc_stop);
      chk_bit("wdt_clear", 1'b1, wdt_clear);
      chk_bit("timeout_flag", 1'b1, timeout_flag);
      chk_bit("powerdown_flag", 1'b0, powerdown_flag);
      @(posedge clock);
      #1;
      chk_bit("wdt_clear", 1'b0, wdt_clear);
      chk_bit("instr_ready", 1'b0, instr_ready);
      wake_pin = 1'b1;
      n = 0;
      while (instr_ready !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      wake_pin = 1'b0;
      chk_bit("instr_ready", 1'b1, instr_ready);
      chk_bit("osc_stop", 1'b0, osc_stop);
      fop(1, 1'b0, 7'h11);
      report_and_stop();
   end
endmodule
